// file: hw/uehc_pkg.sv
// constants of the endpoint 1/2 length and handshake control block
// assumes a 32-bit register port with byte addresses in word steps
package uehc_pkg;
  localparam logic [7:0]  ADDR_EP1_BUF   = 8'h00;
  localparam logic [7:0]  ADDR_EP2_BUF   = 8'h04;
  localparam logic [7:0]  ADDR_EP1_CTRL  = 8'h08;
  localparam logic [7:0]  ADDR_EP2_CTRL  = 8'h0c;
  localparam int          CTRL_LSB       = 16;
  localparam int          OUT_TOG_BIT    = 7;
  localparam int          IN_TOG_BIT     = 6;
  localparam int          AUTO_TOG_BIT   = 4;
  localparam int          OUT_SEL_LSB    = 2;
  localparam int          IN_SEL_LSB     = 0;
  localparam logic [15:0] CTRL_WR_MASK   = 16'h00df;
  localparam int          LEN_BITS       = 7;
  localparam int          BUF_ADDR_BITS  = 15;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] LEN_RESET      = 16'h0000;
  localparam logic [14:0] BUF_RESET      = 15'h0000;
  typedef enum logic [1:0] {
    UEHC_HS_ACK, UEHC_HS_NYET, UEHC_HS_NAK, UEHC_HS_STALL
  } uehc_hs_t;
endpackage

// file: hw/uehc_stream_if.sv
// byte stream between the fetch engine and the two-entry buffer
// assumes producer and consumer share one clock
`timescale 1ns/1ps
`default_nettype none
interface uehc_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  logic         last;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// file: hw/uehc_pair_buf.sv
// two-entry buffer: output register plus skid register
// assumes one clock; outputs come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module uehc_pair_buf #(
  parameter int W = 8
) (
  input  wire logic  i_sys_clk,
  input  wire logic  i_nrst,
  uehc_stream_if.snk s_in,
  uehc_stream_if.src s_out
);
  logic [W:0] skid;
  logic       skid_valid;
  logic       out_valid;
  logic [W:0] out_word;

  assign s_in.ready  = ~skid_valid;
  assign s_out.valid = out_valid;
  assign s_out.data  = out_word[W-1:0];
  assign s_out.last  = out_word[W];

  // skid catches the word taken while the receiver stalls, so none is lost
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_valid  <= 1'b0;
      out_word   <= '0;
      skid_valid <= 1'b0;
      skid       <= '0;
    end else if (s_out.ready || !out_valid) begin
      if (skid_valid) begin
        out_valid  <= 1'b1;
        out_word   <= skid;
        skid_valid <= 1'b0;
      end else begin
        out_valid <= s_in.valid;
        out_word  <= {s_in.last, s_in.data};
      end
    end else if (s_in.valid && !skid_valid) begin
      skid       <= {s_in.last, s_in.data};
      skid_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: hw/uehc_ep_ctrl.sv
// endpoint 1/2 transmit length, data toggle and handshake control
// assumes serial engine and buffer memory on i_sys_clk; memory answers reads with i_mem_rvalid
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uehc_ep_ctrl #(
  parameter int LEN_W = uehc_pkg::LEN_BITS
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  input  wire logic        i_tok_valid,
  input  wire logic        i_tok_ep2,
  input  wire logic        i_tok_in,
  input  wire logic        i_tok_iso,
  output logic             o_ans_valid,
  output logic             o_ans_handshake,
  output logic      [1:0]  o_ans_code,
  output logic             o_ans_check_toggle,
  output logic             o_ans_toggle,
  output logic             o_ans_data,
  output logic      [6:0]  o_ans_len,
  input  wire logic        i_xfer_ok,
  input  wire logic        i_xfer_ep2,
  input  wire logic        i_xfer_in,
  output logic             o_mem_rd,
  output logic      [14:0] o_mem_addr,
  input  wire logic [31:0] i_mem_rdata,
  input  wire logic        i_mem_rvalid,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_data,
  output logic             o_tx_last,
  input  wire logic        i_tx_ready,
  output logic             o_busy
);
  if (LEN_W < 1 || LEN_W > 16) begin : g_bad_len
    $error("LEN_W must lie in 1..16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] ctrl [2];
  logic [15:0] len  [2];
  logic [14:0] buf_start [2];

  function automatic logic [15:0] next_ctrl_of(input logic [15:0] cur, input logic wr,
                                               input logic [31:0] wd, input logic flip,
                                               input logic flip_in);
    logic [15:0] v;
    v = wr ? (wd[31:16] & uehc_pkg::CTRL_WR_MASK) : cur;
    // a hardware flip lands on top of a same-cycle write, but is dropped when the written value clears the auto-toggle bit
    if (flip && v[uehc_pkg::AUTO_TOG_BIT]) begin
      if (flip_in) begin
        v[uehc_pkg::IN_TOG_BIT] = ~v[uehc_pkg::IN_TOG_BIT];
      end else begin
        v[uehc_pkg::OUT_TOG_BIT] = ~v[uehc_pkg::OUT_TOG_BIT];
      end
    end
    return v;
  endfunction

  function automatic logic [15:0] len_mask();
    logic [15:0] m;
    m = '0;
    m[LEN_W-1:0] = '1;
    return m;
  endfunction

  logic wr_ctrl1;
  logic wr_ctrl2;
  assign wr_ctrl1 = i_reg_wr && (i_reg_addr == uehc_pkg::ADDR_EP1_CTRL);
  assign wr_ctrl2 = i_reg_wr && (i_reg_addr == uehc_pkg::ADDR_EP2_CTRL);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl[0] <= uehc_pkg::CTRL_RESET;
      ctrl[1] <= uehc_pkg::CTRL_RESET;
      len[0]  <= uehc_pkg::LEN_RESET;
      len[1]  <= uehc_pkg::LEN_RESET;
    end else begin
      ctrl[0] <= next_ctrl_of(ctrl[0], wr_ctrl1, i_reg_wdata, i_xfer_ok && !i_xfer_ep2, i_xfer_in);
      ctrl[1] <= next_ctrl_of(ctrl[1], wr_ctrl2, i_reg_wdata, i_xfer_ok && i_xfer_ep2, i_xfer_in);
      if (wr_ctrl1) begin
        len[0] <= i_reg_wdata[15:0] & len_mask();
      end
      if (wr_ctrl2) begin
        len[1] <= i_reg_wdata[15:0] & len_mask();
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      buf_start[0] <= uehc_pkg::BUF_RESET;
      buf_start[1] <= uehc_pkg::BUF_RESET;
    end else if (i_reg_wr && i_reg_addr == uehc_pkg::ADDR_EP1_BUF) begin
      buf_start[0] <= i_reg_wdata[14:0];
    end else if (i_reg_wr && i_reg_addr == uehc_pkg::ADDR_EP2_BUF) begin
      buf_start[1] <= i_reg_wdata[14:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        uehc_pkg::ADDR_EP1_BUF:  o_reg_rdata <= {17'h00000, buf_start[0]};
        uehc_pkg::ADDR_EP2_BUF:  o_reg_rdata <= {17'h00000, buf_start[1]};
        uehc_pkg::ADDR_EP1_CTRL: o_reg_rdata <= {ctrl[0], len[0]};
        uehc_pkg::ADDR_EP2_CTRL: o_reg_rdata <= {ctrl[1], len[1]};
        default:                 o_reg_rdata <= '0;
      endcase
    end else begin
      o_reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // token answer
  typedef enum logic [1:0] {UEHC_IDLE, UEHC_FETCH, UEHC_WAIT, UEHC_PUSH} uehc_state_t;
  uehc_state_t state;

  logic [15:0] tok_ctrl;
  logic [1:0]  tok_sel;
  logic        tok_send;
  logic        tok_take;
  assign tok_ctrl = ctrl[i_tok_ep2];
  assign tok_sel  = i_tok_in ? tok_ctrl[uehc_pkg::IN_SEL_LSB +: 2] : tok_ctrl[uehc_pkg::OUT_SEL_LSB +: 2];
  // o_busy low implies idle; gating on it keeps the refusal window equal to what o_busy shows
  assign tok_take = i_tok_valid && !o_busy;
  // IN data goes out on ACK/NYET selections, always for isochronous
  assign tok_send = i_tok_in && (i_tok_iso || !tok_sel[1]);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ans_valid        <= 1'b0;
      o_ans_handshake    <= 1'b0;
      o_ans_code         <= '0;
      o_ans_check_toggle <= 1'b0;
      o_ans_toggle       <= 1'b0;
      o_ans_data         <= 1'b0;
      o_ans_len          <= '0;
    end else begin
      o_ans_valid <= tok_take;
      if (tok_take) begin
        o_ans_handshake    <= !i_tok_iso;
        o_ans_code         <= tok_sel;
        o_ans_check_toggle <= !i_tok_in && !i_tok_iso;
        o_ans_toggle       <= i_tok_in ? tok_ctrl[uehc_pkg::IN_TOG_BIT] : tok_ctrl[uehc_pkg::OUT_TOG_BIT];
        o_ans_data         <= tok_send;
        o_ans_len          <= tok_send ? 7'(len[i_tok_ep2]) : 7'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // IN data fetch
  uehc_stream_if #(.W(8)) fill_if ();
  uehc_stream_if #(.W(8)) drain_if ();

  logic [LEN_W-1:0] left;
  logic [12:0]      word_idx;
  logic [1:0]       byte_sel;
  logic [31:0]      word;
  logic             cur_ep2;
  logic             push;

  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] s);
    return w[8*s +: 8];
  endfunction

  assign fill_if.valid = (state == UEHC_PUSH);
  assign fill_if.data  = byte_of(word, byte_sel);
  assign fill_if.last  = (left == LEN_W'(1));
  assign push          = fill_if.valid && fill_if.ready;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state    <= UEHC_IDLE;
      left     <= '0;
      word_idx <= '0;
      byte_sel <= '0;
      word     <= '0;
      cur_ep2  <= 1'b0;
    end else begin
      unique case (state)
        UEHC_IDLE: begin
          if (tok_take && tok_send && len[i_tok_ep2][LEN_W-1:0] != '0) begin
            left     <= len[i_tok_ep2][LEN_W-1:0];
            word_idx <= '0;
            byte_sel <= '0;
            cur_ep2  <= i_tok_ep2;
            state    <= UEHC_FETCH;
          end
        end
        UEHC_FETCH: state <= UEHC_WAIT;
        UEHC_WAIT: begin
          if (i_mem_rvalid) begin
            word  <= i_mem_rdata;
            state <= UEHC_PUSH;
          end
        end
        UEHC_PUSH: begin
          if (push) begin
            left     <= left - LEN_W'(1);
            byte_sel <= byte_sel + 2'h1;
            if (left == LEN_W'(1)) begin
              state <= UEHC_IDLE;
            end else if (byte_sel == 2'h3) begin
              word_idx <= word_idx + 13'h0001;
              state    <= UEHC_FETCH;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mem_rd   <= 1'b0;
      o_mem_addr <= '0;
    end else begin
      o_mem_rd <= (state == UEHC_FETCH);
      if (state == UEHC_FETCH) begin
        // low two start bits dropped: software keeps the start word aligned
        o_mem_addr <= {buf_start[cur_ep2][14:2] + word_idx, 2'h0};
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state != UEHC_IDLE) || (tok_take && tok_send && len[i_tok_ep2][LEN_W-1:0] != '0);
    end
  end

  uehc_pair_buf #(.W(8)) u_buf (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .s_in      (fill_if.snk),
    .s_out     (drain_if.src)
  );

  assign drain_if.ready = i_tx_ready;
  assign o_tx_valid     = drain_if.valid;
  assign o_tx_data      = drain_if.data;
  assign o_tx_last      = drain_if.last;
endmodule
`default_nettype wire

// file: testbench/uehc_props.sv
// checker of token answers, buffer fetch and stream hold
// assumes it is bound into uehc_ep_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module uehc_props (
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic        i_tok_valid,
  input wire logic        i_tok_in,
  input wire logic        i_tok_iso,
  input wire logic        o_busy,
  input wire logic        o_ans_valid,
  input wire logic        o_ans_handshake,
  input wire logic        o_ans_check_toggle,
  input wire logic        o_ans_data,
  input wire logic [1:0]  o_ans_code,
  input wire logic        o_mem_rd,
  input wire logic [14:0] o_mem_addr,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        i_tx_ready
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // a token counts only when no fetch is running
  wire tk = i_tok_valid && !o_busy;
  ////////////////////////////////////////////////////////////////////////////
  AST_ANS_TIME: assert property (tk |=> o_ans_valid) else $error("answer missing");
  AST_ANS_NONE: assert property (!tk |=> !o_ans_valid) else $error("answer without token");
  AST_ISO: assert property (tk && i_tok_iso |=> !o_ans_handshake && !o_ans_check_toggle)
    else $error("iso answer has handshake");
  AST_OUT: assert property (tk && !i_tok_in && !i_tok_iso |=> o_ans_handshake && o_ans_check_toggle && !o_ans_data)
    else $error("out answer wrong");
  AST_IN: assert property (tk && i_tok_in && !i_tok_iso |=> o_ans_data == !o_ans_code[1])
    else $error("in data flag wrong");
  AST_ALIGN: assert property (o_mem_rd |-> o_mem_addr[1:0] == 2'h0) else $error("fetch not aligned");
  AST_STALL: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("byte lost on stall");
  AST_FETCH_BUSY: assert property (o_mem_rd |-> o_busy) else $error("fetch while idle");
  C_DATA_IN: cover property (tk && i_tok_in && !i_tok_iso ##1 o_ans_data);
  C_STALL: cover property (o_tx_valid && !i_tx_ready);
  C_ISO: cover property (tk && i_tok_iso);
endmodule
bind uehc_ep_ctrl uehc_props u_props (.i_sys_clk, .i_nrst, .i_tok_valid, .i_tok_in, .i_tok_iso, .o_busy,
  .o_ans_valid, .o_ans_handshake, .o_ans_check_toggle, .o_ans_data, .o_ans_code, .o_mem_rd, .o_mem_addr,
  .o_tx_valid, .o_tx_data, .i_tx_ready);
`default_nettype wire

// file: testbench/uehc_host_mem.sv
// buffer memory and byte receiver facing the endpoint block
// assumes one clock; a word read is answered 1 to 4 cycles after the read strobe is sampled
`timescale 1ns/1ps
`default_nettype none
module uehc_host_mem (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_mem_rd,
  input  wire logic [14:0] i_mem_addr,
  output logic      [31:0] o_mem_rdata,
  output logic             o_mem_rvalid,
  output logic             o_tx_ready
);
  logic [14:0] addr;
  logic [1:0]  wait_n;
  logic        pend;
  function automatic logic [7:0] mbyte(input logic [14:0] a, input int i);
    return 8'(a[7:0] + i) ^ 8'h5a;
  endfunction
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {pend, o_mem_rvalid, o_tx_ready, o_mem_rdata} <= '0;
    end else begin
      o_tx_ready <= $urandom_range(3, 0) != 0;
      o_mem_rvalid <= 1'b0;
      // stale word keeps changing so it can never pass for data
      o_mem_rdata <= ~o_mem_rdata;
      if (i_mem_rd) begin
        pend <= 1'b1;
        addr <= i_mem_addr;
        wait_n <= 2'($urandom_range(3, 0));
      end else if (pend && wait_n != 2'h0) begin
        wait_n <= wait_n - 2'h1;
      end else if (pend) begin
        pend <= 1'b0;
        o_mem_rvalid <= 1'b1;
        o_mem_rdata <= {mbyte(addr, 3), mbyte(addr, 2), mbyte(addr, 1), mbyte(addr, 0)};
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_usb_endpoint_handshake_ctrl.sv
// self-checking bench of the endpoint 1/2 control block
// assumes uehc_host_mem as buffer memory and byte receiver
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_handshake_ctrl;
  logic        i_sys_clk, i_nrst, i_reg_wr, i_reg_rd, i_tok_valid, i_tok_ep2, i_tok_in, i_tok_iso;
  logic        i_xfer_ok, i_xfer_ep2, i_xfer_in, i_mem_rvalid, i_tx_ready, o_ans_valid, o_ans_handshake;
  logic        o_ans_check_toggle, o_ans_toggle, o_ans_data, o_mem_rd, o_tx_valid, o_tx_last, o_busy;
  logic [1:0]  o_ans_code;
  logic [4:0]  v;
  logic [6:0]  o_ans_len;
  logic [7:0]  i_reg_addr, o_tx_data, ca;
  logic [14:0] o_mem_addr, start;
  logic [31:0] i_reg_wdata, o_reg_rdata, i_mem_rdata, w;
  int          miscompares, cmp_count, cyc, rx_n, len, k;
  wire  [5:0]  ans = {o_ans_handshake, o_ans_code, o_ans_check_toggle, o_ans_toggle, o_ans_data};
  uehc_ep_ctrl u_dut (.i_sys_clk, .i_nrst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_tok_valid, .i_tok_ep2, .i_tok_in, .i_tok_iso, .o_ans_valid, .o_ans_handshake, .o_ans_code,
    .o_ans_check_toggle, .o_ans_toggle, .o_ans_data, .o_ans_len, .i_xfer_ok, .i_xfer_ep2, .i_xfer_in,
    .o_mem_rd, .o_mem_addr, .i_mem_rdata, .i_mem_rvalid, .o_tx_valid, .o_tx_data, .o_tx_last, .i_tx_ready, .o_busy);
  uehc_host_mem u_host (.i_sys_clk, .i_nrst, .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
    .o_mem_rdata(i_mem_rdata), .o_mem_rvalid(i_mem_rvalid), .o_tx_ready(i_tx_ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d of %0d compares", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    {i_reg_rd, i_reg_addr} <= {1'b1, a};
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, e);
  endtask
  task automatic tok(input logic e2, input logic in, input logic iso);
    @(posedge i_sys_clk);
    {i_tok_valid, i_tok_ep2, i_tok_in, i_tok_iso} <= {1'b1, e2, in, iso};
    @(posedge i_sys_clk);
    i_tok_valid <= 1'b0;
    #1 chk(o_ans_valid, 1'b1);
  endtask
  task automatic xfer(input logic e2, input logic in);
    @(posedge i_sys_clk);
    {i_xfer_ok, i_xfer_ep2, i_xfer_in} <= {1'b1, e2, in};
    @(posedge i_sys_clk);
    i_xfer_ok <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // receiver side: bytes must follow the buffer from its start, in order
  always @(posedge i_sys_clk) begin
    if (i_nrst && o_tx_valid && i_tx_ready) begin
      chk({o_tx_last, o_tx_data}, {rx_n == len - 1, 8'(start[7:0] + rx_n) ^ 8'h5a});
      rx_n <= rx_n + 1;
    end
  end
  initial begin
    {i_nrst, i_reg_wr, i_reg_rd, i_tok_valid, i_xfer_ok, i_tok_ep2, i_tok_in, i_tok_iso} = '0;
    {i_reg_addr, i_reg_wdata, i_xfer_ep2, i_xfer_in, miscompares, cmp_count, cyc, rx_n, len} = '0;
    w = $urandom(32'hc6c2beea);
    repeat (4) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0);
    for (int i = 0; i < 12; i++) begin
      w = $urandom;
      wr(8'(4 * (i % 4)), w);
      rdc(8'(4 * (i % 4)), (i % 4) > 1 ? {w[31:16] & uehc_pkg::CTRL_WR_MASK, 9'h0, w[6:0]} : {17'h0, w[14:0]});
    end
    wr(8'h10, 32'hffffffff);
    rdc(8'h10, 32'h0);
    for (int i = 0; i < 32; i++) begin
      v = 5'(i);
      wr(v[4] ? uehc_pkg::ADDR_EP2_CTRL : uehc_pkg::ADDR_EP1_CTRL, {8'h0, v[3], v[3], 2'h0, v[1:0], v[1:0], 16'h0});
      tok(v[4], v[2], 1'b0);
      chk(ans, {1'b1, v[1:0], !v[2], v[3], v[2] && !v[1]});
      tok(v[4], v[2], 1'b1);
      chk({ans[5], ans[2:0]}, {2'h0, v[3], v[2]});
    end
    for (int i = 0; i < 8; i++) begin
      v = 5'(i);
      ca = v[0] ? uehc_pkg::ADDR_EP2_CTRL : uehc_pkg::ADDR_EP1_CTRL;
      wr(ca, {11'h0, v[2], 20'h0});
      xfer(v[0], v[1]);
      rdc(ca, {8'h0, v[2] && !v[1], v[2] && v[1], 1'b0, v[2], 20'h0});
    end
    for (int i = 0; i < 6; i++) begin
      len = i == 0 ? 1 : i == 1 ? 127 : $urandom_range(20, 2);
      start = 15'($urandom) & 15'h7ffc;
      rx_n = 0;
      wr(i[0] ? uehc_pkg::ADDR_EP2_BUF : uehc_pkg::ADDR_EP1_BUF, {17'h0, start});
      wr(i[0] ? uehc_pkg::ADDR_EP2_CTRL : uehc_pkg::ADDR_EP1_CTRL, 32'(len));
      tok(i[0], 1'b1, 1'b0);
      chk(o_ans_len, len);
      for (k = 0; k < 2000 && (rx_n != len || o_busy !== 1'b0); k++) @(posedge i_sys_clk);
      chk(rx_n, len);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
